/* File: core/wsl_pkg.sv */
/*
  Package of the deep-sleep wake-up start logic: register byte addresses,
  field positions, reset values, bus answer codes and the carrier structs.
  Assumes a 32-bit AXI4-Lite register bus with full byte addresses.
*/
package wsl_pkg;

  // ==========================================================
  // Start inputs
  localparam int WSL_NUM_START = 13;
  localparam int WSL_P0_PINS = 12;
  localparam int WSL_P1_BIT = 12;

  // ==========================================================
  // Register byte addresses
  localparam logic [31:0] WSL_ADDR_EDGE_SEL = 32'h40048200;
  localparam logic [31:0] WSL_ADDR_WAKE_EN = 32'h40048204;
  localparam logic [31:0] WSL_ADDR_WAKE_CLR = 32'h40048208;
  localparam logic [31:0] WSL_ADDR_WAKE_PEND = 32'h4004820c;
  localparam logic [31:0] WSL_ADDR_PDCFG = 32'h40048230;

  // ==========================================================
  // Reset values and fields
  localparam logic [12:0] WSL_EDGE_SEL_RST = 13'h0000;
  localparam logic [12:0] WSL_WAKE_EN_RST = 13'h0000;
  localparam logic [12:0] WSL_PDCFG_RST = 13'h0000;
  localparam int WSL_PDCFG_BOD_BIT = 3;
  localparam int WSL_PDCFG_WDOG_BIT = 6;

  // ==========================================================
  // Bus answers
  localparam logic [1:0] WSL_RESP_OKAY = 2'h0;
  localparam logic [1:0] WSL_RESP_SLVERR = 2'h2;

  // ==========================================================
  // Carriers between bus front end and register file
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } wsl_wr_req_t;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
  } wsl_rd_req_t;

  typedef struct packed {
    logic ok;
    logic [31:0] data;
  } wsl_rd_rsp_t;

endpackage

/* File: core/wsl_edge_cell.sv */
/*
  One start-logic capture cell: watches one pin, catches the selected
  edge and holds the captured start state until cleared.
  Assumes the pin is synchronous to core_clk.
*/
`timescale 1ns/100ps
module wsl_edge_cell (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic pin,
  input wire logic edge_rise,
  input wire logic clr,
  output logic state
);
  import wsl_pkg::*;

  logic prev_r;
  logic prev_nxt;
  logic armed_r;
  logic armed_nxt;
  logic state_r;
  logic state_nxt;
  logic hit;

  // ==========================================================
  // Capture
  // Armed one cycle after reset so a pin high at release is no rising edge
  always_comb begin
    prev_nxt = pin;
    armed_nxt = 1'b1;
    hit = armed_r && (edge_rise ? (pin && !prev_r) : (!pin && prev_r));
    state_nxt = hit || (state_r && !clr);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= 1'b0;
      armed_r <= 1'b0;
      state_r <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
      armed_r <= armed_nxt;
      state_r <= state_nxt;
    end
  end

  assign state = state_r;

  // ==========================================================
  // Checks
  a_fall_capture: assert property (@(posedge core_clk) disable iff (!rst_n)
    armed_r && !edge_rise && prev_r && !pin |=> state_r)
    else $error("falling edge not captured");

  a_rise_capture: assert property (@(posedge core_clk) disable iff (!rst_n)
    armed_r && edge_rise && !prev_r && pin |=> state_r)
    else $error("rising edge not captured");

  a_state_holds: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_r && !clr |=> state_r)
    else $error("captured state lost without clear");

  a_clear_state: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_r && clr && (edge_rise ? !(pin && !prev_r) : !(!pin && prev_r)) |=> !state_r)
    else $error("clear did not reset state");

  a_no_spurious: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(state_r) |-> $past(armed_r) && ($past(edge_rise) ? ($past(pin) && !$past(prev_r))
                                                          : (!$past(pin) && $past(prev_r))))
    else $error("state set without selected edge");

endmodule

/* File: core/wsl_axil_slave.sv */
/*
  AXI4-Lite slave front end: takes write address and data in either
  order, issues one write strobe to the register file, answers reads one
  cycle after the address is taken. Assumes one outstanding access per direction.
*/
`timescale 1ns/100ps
module wsl_axil_slave (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output wsl_pkg::wsl_wr_req_t wr_req,
  input wire logic wr_ok,
  output wsl_pkg::wsl_rd_req_t rd_req,
  input wsl_pkg::wsl_rd_rsp_t rd_rsp
);
  import wsl_pkg::*;

  logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
  logic [31:0] awaddr_r, awaddr_nxt, wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic do_wr;
  logic ar_fire;

  // ==========================================================
  // Write and read channels
  assign do_wr = aw_held_r && w_held_r && !bvalid_r;
  assign ar_fire = s_axi_arvalid && arready_r;

  always_comb begin
    aw_held_nxt = aw_held_r;
    w_held_nxt = w_held_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    if (s_axi_awvalid && awready_r) begin
      aw_held_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r) begin
      w_held_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (do_wr) begin
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = wr_ok ? WSL_RESP_OKAY : WSL_RESP_SLVERR;
    end
    // Hold off new writes until the response has gone
    awready_nxt = !aw_held_nxt && !bvalid_nxt;
    wready_nxt = !w_held_nxt && !bvalid_nxt;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (ar_fire) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = rd_rsp.data;
      rresp_nxt = rd_rsp.ok ? WSL_RESP_OKAY : WSL_RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 32'h00000000;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= WSL_RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= WSL_RESP_OKAY;
    end else begin
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  assign wr_req = '{valid: do_wr, addr: awaddr_r, data: wdata_r, strb: wstrb_r};
  assign rd_req = '{valid: ar_fire, addr: s_axi_araddr};
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

endmodule

/* File: core/wsl_start_logic.sv */
/*
  Top of the deep-sleep wake-up start logic: edge-select, enable, clear
  and pending-status registers for 13 start inputs, the deep-sleep power
  configuration register, and the registered wake-up interrupt lines.
  Assumes pins synchronous to core_clk and an AXI4-Lite master.
*/
`timescale 1ns/100ps
module wsl_start_logic (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [11:0] port0_pin,
  input wire logic port1_pin0,
  output logic [12:0] wake_irq,
  output logic brownout_sleep_off,
  output logic wdog_osc_sleep_off
);
  import wsl_pkg::*;

  wsl_wr_req_t wr_req;
  wsl_rd_req_t rd_req;
  wsl_rd_rsp_t rd_rsp;
  logic wr_ok;

  logic [12:0] edge_sel_r, edge_sel_nxt;
  logic [12:0] wake_en_r, wake_en_nxt;
  logic [12:0] pdcfg_r, pdcfg_nxt;
  logic [12:0] clr_pulse;
  logic [12:0] cap_state;
  logic [12:0] pend;
  logic [12:0] start_pins;
  logic [12:0] wake_irq_r, wake_irq_nxt;
  logic bod_off_r, bod_off_nxt;
  logic wdog_off_r, wdog_off_nxt;

  // ==========================================================
  // Helpers
  // Bytes 2 and 3 carry only reserved bits, so only two lanes matter
  function automatic logic [12:0] lane_mask(input logic [3:0] strb);
    lane_mask = {{5{strb[1]}}, {8{strb[0]}}};
  endfunction

  function automatic logic [12:0] merge13(input logic [12:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
    merge13 = (old & ~lane_mask(strb)) | (data[12:0] & lane_mask(strb));
  endfunction

  // ==========================================================
  // Bus front end
  wsl_axil_slave u_bus (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_req(wr_req),
    .wr_ok(wr_ok),
    .rd_req(rd_req),
    .rd_rsp(rd_rsp)
  );

  // ==========================================================
  // Register writes
  // Reserved bits 31:13 are simply not stored
  always_comb begin
    edge_sel_nxt = edge_sel_r;
    wake_en_nxt = wake_en_r;
    pdcfg_nxt = pdcfg_r;
    clr_pulse = 13'h0000;
    wr_ok = 1'b0;
    if (wr_req.valid) begin
      case (wr_req.addr)
        WSL_ADDR_EDGE_SEL: begin
          edge_sel_nxt = merge13(edge_sel_r, wr_req.data, wr_req.strb);
          wr_ok = 1'b1;
        end
        WSL_ADDR_WAKE_EN: begin
          wake_en_nxt = merge13(wake_en_r, wr_req.data, wr_req.strb);
          wr_ok = 1'b1;
        end
        WSL_ADDR_WAKE_CLR: begin
          clr_pulse = wr_req.data[12:0] & lane_mask(wr_req.strb);
          wr_ok = 1'b1;
        end
        WSL_ADDR_WAKE_PEND: begin
          // Read-only: write accepted and dropped
          wr_ok = 1'b1;
        end
        WSL_ADDR_PDCFG: begin
          pdcfg_nxt = merge13(pdcfg_r, wr_req.data, wr_req.strb);
          wr_ok = 1'b1;
        end
        default: begin
          wr_ok = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      edge_sel_r <= WSL_EDGE_SEL_RST;
      wake_en_r <= WSL_WAKE_EN_RST;
      pdcfg_r <= WSL_PDCFG_RST;
    end else begin
      edge_sel_r <= edge_sel_nxt;
      wake_en_r <= wake_en_nxt;
      pdcfg_r <= pdcfg_nxt;
    end
  end

  // ==========================================================
  // Register reads
  always_comb begin
    rd_rsp = '{ok: 1'b1, data: 32'h00000000};
    case (rd_req.addr)
      WSL_ADDR_EDGE_SEL: begin
        rd_rsp.data = {19'h00000, edge_sel_r};
      end
      WSL_ADDR_WAKE_EN: begin
        rd_rsp.data = {19'h00000, wake_en_r};
      end
      WSL_ADDR_WAKE_CLR: begin
        rd_rsp.data = 32'h00000000;
      end
      WSL_ADDR_WAKE_PEND: begin
        rd_rsp.data = {19'h00000, pend};
      end
      WSL_ADDR_PDCFG: begin
        rd_rsp.data = {19'h00000, pdcfg_r};
      end
      default: begin
        rd_rsp.ok = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Start capture cells
  assign start_pins = {port1_pin0, port0_pin};

  generate
    for (genvar i = 0; i < WSL_NUM_START; i++) begin : g_cell
      wsl_edge_cell u_cell (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pin(start_pins[i]),
        .edge_rise(edge_sel_r[i]),
        .clr(clr_pulse[i]),
        .state(cap_state[i])
      );
    end
  endgenerate

  // Capture runs even when disabled; enable only gates what is seen
  assign pend = cap_state & wake_en_r;

  // ==========================================================
  // Outputs
  always_comb begin
    wake_irq_nxt = pend;
    bod_off_nxt = pdcfg_r[WSL_PDCFG_BOD_BIT];
    wdog_off_nxt = pdcfg_r[WSL_PDCFG_WDOG_BIT];
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_irq_r <= 13'h0000;
      bod_off_r <= 1'b0;
      wdog_off_r <= 1'b0;
    end else begin
      wake_irq_r <= wake_irq_nxt;
      bod_off_r <= bod_off_nxt;
      wdog_off_r <= wdog_off_nxt;
    end
  end

  assign wake_irq = wake_irq_r;
  assign brownout_sleep_off = bod_off_r;
  assign wdog_osc_sleep_off = wdog_off_r;

  // ==========================================================
  // Checks
  a_irq_follows_pend: assert property (@(posedge core_clk) disable iff (!rst_n)
    1'b1 |=> wake_irq == ($past(cap_state) & $past(wake_en_r)))
    else $error("wake interrupt does not match enabled capture");

  a_port1_pin_map: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(rst_n) && !edge_sel_r[12] && $past(port1_pin0) && !port1_pin0 |=> cap_state[12])
    else $error("port 1 pin 0 does not reach bit 12");

  a_port0_pin_map: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(rst_n) && edge_sel_r[0] && !$past(port0_pin[0]) && port0_pin[0] |=> cap_state[0])
    else $error("port 0 pin 0 does not reach bit 0");

  a_enable_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_req.valid && wr_req.addr == WSL_ADDR_WAKE_EN && wr_req.strb == 4'hf
    |=> wake_en_r == $past(wr_req.data[12:0]))
    else $error("enable write not stored");

  a_status_gated: assert property (@(posedge core_clk) disable iff (!rst_n)
    rd_req.valid && rd_req.addr == WSL_ADDR_WAKE_PEND
    |=> s_axi_rvalid && s_axi_rdata == {19'h00000, $past(cap_state) & $past(wake_en_r)})
    else $error("status read shows disabled or wrong state");

  a_status_pending: assert property (@(posedge core_clk) disable iff (!rst_n)
    rd_req.valid && rd_req.addr == WSL_ADDR_WAKE_PEND && pend[0]
    |=> s_axi_rdata[0])
    else $error("pending input reads as zero");

  a_bod_sleep_ctl: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_req.valid && wr_req.addr == WSL_ADDR_PDCFG && wr_req.strb[0]
    |=> ##1 brownout_sleep_off == $past(wr_req.data[3], 2))
    else $error("brownout sleep control not applied");

  a_wdog_sleep_ctl: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_req.valid && wr_req.addr == WSL_ADDR_PDCFG && wr_req.strb[0]
    |=> ##1 wdog_osc_sleep_off == $past(wr_req.data[6], 2))
    else $error("watchdog oscillator sleep control not applied");

  a_edge_reset_val: assert property (@(posedge core_clk)
    $rose(rst_n) |-> edge_sel_r == 13'h0000 && wake_en_r == 13'h0000)
    else $error("edge select or enable not zero after reset");

  a_irq_reset_val: assert property (@(posedge core_clk)
    $rose(rst_n) |-> wake_irq == 13'h0000 && pdcfg_r == 13'h0000)
    else $error("wake interrupt or power config not zero after reset");

  a_edge_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_req.valid && wr_req.addr == WSL_ADDR_EDGE_SEL && wr_req.strb == 4'hf
    |=> edge_sel_r == $past(wr_req.data[12:0]))
    else $error("edge select write not stored");

  a_cfg_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_req.valid && wr_req.addr == WSL_ADDR_PDCFG && wr_req.strb == 4'hf
    |=> pdcfg_r == $past(wr_req.data[12:0]))
    else $error("power config write not stored");

  a_capture_kept: assert property (@(posedge core_clk) disable iff (!rst_n)
    1'b1 |=> (($past(cap_state) & ~$past(clr_pulse)) & ~cap_state) == 13'h0000)
    else $error("captured state dropped without clear");

  a_clear_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_req.valid && wr_req.addr == WSL_ADDR_WAKE_CLR
    |=> (($past(cap_state) & ~$past(wr_req.data[12:0])) & ~cap_state) == 13'h0000)
    else $error("zero in clear write changed a state");

  a_irq_gated: assert property (@(posedge core_clk) disable iff (!rst_n)
    1'b1 |=> (wake_irq & ~$past(wake_en_r)) == 13'h0000)
    else $error("disabled input raised its wake interrupt");

  a_status_upper: assert property (@(posedge core_clk) disable iff (!rst_n)
    rd_req.valid && rd_req.addr == WSL_ADDR_WAKE_PEND
    |=> s_axi_rdata[31:13] == 19'h00000)
    else $error("status read shows reserved bits set");

endmodule

/* File: bench/wsl_pin_model.sv */
/*
  Far-side model: drives the 13 start pins and stands in for the core
  interrupt controller that samples the wake-up lines.
  Assumes the bench moves pin levels on rising edges of core_clk.
*/
`timescale 1ns/100ps
module wsl_pin_model (
  input wire logic core_clk,
  input wire logic [12:0] lvl,
  input wire logic [12:0] ctl_en,
  input wire logic [12:0] wake_irq,
  output logic [11:0] port0_pin,
  output logic port1_pin0,
  output logic [12:0] irq_pend
);
  // ==========================================================
  // Pins and controller
  always_ff @(posedge core_clk) begin
    port0_pin <= lvl[11:0];
    port1_pin0 <= lvl[12];
    // Only lines software enabled in the controller reach the core
    irq_pend <= wake_irq & ctl_en;
  end
endmodule

/* File: bench/wsl_start_logic_tb_top.sv */
/*
  Self-checking bench of the wake-up start logic: AXI4-Lite master tasks,
  random pin, clear, enable and edge-select traffic, power config words.
  Assumes the pin model in wsl_pin_model and the design package.
*/
`timescale 1ns/100ps
`define CHK(nm, e, s) begin tests_run++; if ((e) !== (s)) begin n_fail++; $display("FAIL %s exp %h got %h", nm, e, s); end end
module wsl_start_logic_tb_top;
  import wsl_pkg::*;
  logic core_clk, rst_n;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [11:0] port0_pin;
  logic port1_pin0, brownout_sleep_off, wdog_osc_sleep_off;
  logic [12:0] wake_irq, lvl, ctl_en, irq_pend, cap, en_m, sel_m;
  logic [31:0] d;
  // Words with the oscillator running assume its code and clock gates already set
  logic [31:0] cfg [4] = '{32'h000018b7, 32'h000018f7, 32'h000018bf, 32'h000018ff};
  int n_fail, tests_run;

  wsl_start_logic dut (.core_clk(core_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .port0_pin(port0_pin), .port1_pin0(port1_pin0), .wake_irq(wake_irq),
    .brownout_sleep_off(brownout_sleep_off), .wdog_osc_sleep_off(wdog_osc_sleep_off));

  wsl_pin_model pins (.core_clk(core_clk), .lvl(lvl), .ctl_en(ctl_en), .wake_irq(wake_irq),
    .port0_pin(port0_pin), .port1_pin0(port1_pin0), .irq_pend(irq_pend));

  always #5 core_clk = ~core_clk;

  // ==========================================================
  // Expectation and bus tasks
  function automatic logic [12:0] edges(input logic [12:0] p, input logic [12:0] n, input logic [12:0] s);
    return (s & ~p & n) | (~s & p & ~n);
  endfunction

  task automatic axw(input logic [31:0] a, input logic [31:0] v, output logic [1:0] rs);
    bit aw_d;
    bit w_d;
    aw_d = 0;
    w_d = 0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_d && w_d)) begin
      @(posedge core_clk);
      if (!aw_d && s_axi_awready === 1'b1) begin
        aw_d = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_d && s_axi_wready === 1'b1) begin
        w_d = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge core_clk);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axr(input logic [31:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge core_clk);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rchk(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] v;
    logic [1:0] rs;
    axr(a, v, rs);
    `CHK("rdata", e, v)
    `CHK("rresp", er, rs)
  endtask

  task automatic wchk(input logic [31:0] a, input logic [31:0] v, input logic [1:0] er);
    logic [1:0] rs;
    axw(a, v, rs);
    `CHK("bresp", er, rs)
  endtask

  // ==========================================================
  // Pin and register actions, then the full port check
  task automatic pin_to(input logic [12:0] nl);
    @(posedge core_clk);
    cap = cap | edges(lvl, nl, sel_m);
    lvl <= nl;
    repeat (4) @(posedge core_clk);
  endtask

  task automatic check_all();
    repeat (3) @(posedge core_clk);
    `CHK("wake_irq", cap & en_m, wake_irq)
    `CHK("irq_pend", cap & en_m & ctl_en, irq_pend)
    rchk(WSL_ADDR_WAKE_PEND, {19'h0, cap & en_m}, WSL_RESP_OKAY);
  endtask

  task automatic results();
    $display("counts: tests_run %0d n_fail %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    results();
  end

  // ==========================================================
  // Main sequence
  initial begin
    core_clk = 0;
    rst_n = 0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    lvl = '0;
    cap = '0;
    en_m = '0;
    sel_m = '0;
    n_fail = 0;
    tests_run = 0;
    void'($urandom(43786));
    ctl_en = 13'($urandom);
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    `CHK("wake_irq", 13'h0, wake_irq)
    `CHK("bod_off", 1'b0, brownout_sleep_off)
    `CHK("wdog_off", 1'b0, wdog_osc_sleep_off)
    rchk(WSL_ADDR_EDGE_SEL, 32'h0, WSL_RESP_OKAY);
    rchk(WSL_ADDR_WAKE_EN, 32'h0, WSL_RESP_OKAY);
    rchk(WSL_ADDR_PDCFG, 32'h0, WSL_RESP_OKAY);
    rchk(WSL_ADDR_WAKE_CLR, 32'h0, WSL_RESP_OKAY);
    wchk(WSL_ADDR_WAKE_PEND, 32'h1fff, WSL_RESP_OKAY);
    rchk(WSL_ADDR_WAKE_PEND, 32'h0, WSL_RESP_OKAY);
    wchk(32'h40048210, 32'hffffffff, WSL_RESP_SLVERR);
    rchk(32'h40048210, 32'h0, WSL_RESP_SLVERR);
    $display("test reset_map done");
    // Reserved bits stay zero on every write, as software must keep them
    d = {19'h0, 13'($urandom)};
    wchk(WSL_ADDR_EDGE_SEL, d, WSL_RESP_OKAY);
    rchk(WSL_ADDR_EDGE_SEL, {19'h0, d[12:0]}, WSL_RESP_OKAY);
    d = {19'h0, 13'($urandom)};
    wchk(WSL_ADDR_WAKE_EN, d, WSL_RESP_OKAY);
    rchk(WSL_ADDR_WAKE_EN, {19'h0, d[12:0]}, WSL_RESP_OKAY);
    $display("test reserved_bits done");
    foreach (cfg[i]) begin
      wchk(WSL_ADDR_PDCFG, cfg[i], WSL_RESP_OKAY);
      repeat (2) @(posedge core_clk);
      `CHK("bod_off", cfg[i][WSL_PDCFG_BOD_BIT], brownout_sleep_off)
      `CHK("wdog_off", cfg[i][WSL_PDCFG_WDOG_BIT], wdog_osc_sleep_off)
      rchk(WSL_ADDR_PDCFG, cfg[i], WSL_RESP_OKAY);
    end
    $display("test power_config done");
    wchk(WSL_ADDR_EDGE_SEL, 32'h0, WSL_RESP_OKAY);
    wchk(WSL_ADDR_WAKE_EN, 32'h1fff, WSL_RESP_OKAY);
    wchk(WSL_ADDR_WAKE_CLR, 32'h1fff, WSL_RESP_OKAY);
    en_m = 13'h1fff;
    pin_to(13'h1fff);
    check_all();
    pin_to(13'h0000);
    check_all();
    wchk(WSL_ADDR_WAKE_CLR, 32'h1fff, WSL_RESP_OKAY);
    cap = '0;
    check_all();
    $display("test falling_all done");
    repeat (60) begin
      case ($urandom_range(3, 0))
        0: pin_to(13'($urandom));
        1: begin
          d = {19'h0, 13'($urandom)};
          wchk(WSL_ADDR_WAKE_CLR, d, WSL_RESP_OKAY);
          cap = cap & ~d[12:0];
        end
        2: begin
          en_m = 13'($urandom);
          wchk(WSL_ADDR_WAKE_EN, {19'h0, en_m}, WSL_RESP_OKAY);
        end
        default: begin
          sel_m = 13'($urandom);
          wchk(WSL_ADDR_EDGE_SEL, {19'h0, sel_m}, WSL_RESP_OKAY);
        end
      endcase
      check_all();
    end
    $display("test random_capture done");
    results();
  end
endmodule
